// >>> core/tcc_pkg.sv
// Notes on behaviour
// - Clear field 001 in control bits 7..5 clears the counter on register A match.
// - Edge field 00 in control bits 4..3 counts on rising edges of selected clock.
// - Prescale field 000 in control bits 2..0 counts every internal clock cycle.
// - Field in io_control_ab bits 6..4 at 000 blocks pin output on B match outside PWM mode.
// - Field in io_control_ab bits 2..0 at 000 blocks pin output on A match.
// - Field in io_control_cd bits 6..4 at 000 blocks pin output on D match outside PWM mode.
// - Field in io_control_cd bits 2..0 at 000 blocks pin output on C match outside PWM mode.
// - Status bit 0 reads 1 after a register A match, 0 while none occurred.
// - Prescale field 001 counts the internal clock divided by two.
// - PWM mode: A match drives B, C, D pins low; B, C, D matches drive high.
package tcc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_TIMER_CONTROL = 16'hF700;
	localparam logic [15:0] IDX_IO_CONTROL_AB = 16'hF701;
	localparam logic [15:0] IDX_IO_CONTROL_CD = 16'hF702;
	localparam logic [15:0] IDX_TIMER_STATUS  = 16'hF703;
	localparam logic [15:0] IDX_CHANNEL_CNT   = 16'hF706;
	localparam logic [15:0] IDX_PWM_MODE      = 16'hF707;
	localparam logic [15:0] IDX_GENERAL_A     = 16'hF708;
	localparam logic [15:0] IDX_GENERAL_B     = 16'hF709;
	localparam logic [15:0] IDX_GENERAL_C     = 16'hF70A;
	localparam logic [15:0] IDX_GENERAL_D     = 16'hF70B;
	localparam logic [15:0] IDX_INT_STATUS    = 16'hF70C;
	localparam logic [15:0] IDX_INT_MASK      = 16'hF70D;
	localparam int          ADDR_W            = 18;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CLR_HI  = 7;
	localparam int CLR_LO  = 5;
	localparam int EDGE_HI = 4;
	localparam int EDGE_LO = 3;
	localparam int PSC_HI  = 2;
	localparam int PSC_LO  = 0;
	localparam int OUTH_HI = 6; // B or D field
	localparam int OUTH_LO = 4;
	localparam int OUTL_HI = 2; // A or C field
	localparam int OUTL_LO = 0;
	localparam int FLAG_A  = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Field encodings
	localparam logic [2:0] CLR_ON_A    = 3'h1;
	localparam logic [2:0] CLR_ON_B    = 3'h2;
	localparam logic [2:0] CLR_ON_C    = 3'h3;
	localparam logic [2:0] CLR_ON_D    = 3'h6;
	localparam logic [1:0] EDGE_RISE   = 2'h0;
	localparam logic [1:0] EDGE_FALL   = 2'h1;
	localparam logic [2:0] PSC_DIV1    = 3'h0;
	localparam logic [2:0] PSC_DIV2    = 3'h1;
	localparam logic [2:0] PSC_DIV4    = 3'h2;
	localparam logic [2:0] PSC_DIV8    = 3'h3;
	localparam logic [2:0] OUT_OFF     = 3'h0;
	localparam logic [2:0] OUT_LOW     = 3'h1;
	localparam logic [2:0] OUT_HIGH    = 3'h2;
	localparam logic [2:0] OUT_TOGGLE  = 3'h3;
	localparam int         INT_BITS    = 5;
	localparam int         INT_MATCH_A = 0;
	localparam int         INT_MATCH_B = 1;
	localparam int         INT_MATCH_C = 2;
	localparam int         INT_MATCH_D = 3;
	localparam int         INT_OVF     = 4;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite carriers
	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} tcc_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} tcc_axi_rsp_s;

endpackage

// >>> core/tcc_timer_channel.sv
// The AXI4-Lite register port is this design's own decision.
module tcc_timer_channel #(
	parameter int CNT_W = 16 // Counter and general register width
) (
	input  wire logic                  clk,       // 100 MHz clock
	input  wire logic                  rst,       // Synchronous reset, active high
	input  wire tcc_pkg::tcc_axi_req_s axiReq,    // Bus master signals
	output tcc_pkg::tcc_axi_rsp_s      axiRsp,    // Bus slave signals
	output logic                       compareOutA, // Register A compare pin
	output logic                       pwmOutB,   // Chopping output B
	output logic                       pwmOutC,   // Chopping output C
	output logic                       pwmOutD,   // Chopping output D
	output logic                       irq        // Level interrupt
);

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0]                  timerControl;
	logic [7:0]                  ioControlAb;
	logic [7:0]                  ioControlCd;
	logic                        matchAFlag;
	logic                        flagReadSeen;
	logic                        pwmModeEn;
	logic [CNT_W-1:0]            channelCounter;
	logic [CNT_W-1:0]            generalRegA;
	logic [CNT_W-1:0]            generalRegB;
	logic [CNT_W-1:0]            generalRegC;
	logic [CNT_W-1:0]            generalRegD;
	logic [tcc_pkg::INT_BITS-1:0] intStatus;
	logic [tcc_pkg::INT_BITS-1:0] intMask;

	// Bus state
	logic                        awHeld;
	logic                        wHeld;
	logic [tcc_pkg::ADDR_W-1:0]  awAddrReg;
	logic [31:0]                 wDataReg;
	logic [3:0]                  wStrbReg;
	logic                        bvalidReg;
	logic [1:0]                  brespReg;
	logic                        rvalidReg;
	logic [31:0]                 rdataReg;
	logic [1:0]                  rrespReg;

	// Timing and match state
	logic [2:0]                  divCnt;
	logic                        prevDivClk;
	logic                        divClk;
	logic                        countTick;
	logic                        matchA;
	logic                        matchB;
	logic                        matchC;
	logic                        matchD;
	logic                        overflow;
	logic                        clearHit;

	// Decoded fields
	logic [2:0]                  clrSel;
	logic [1:0]                  edgeSel;
	logic [2:0]                  pscSel;
	logic [2:0]                  outCtrlA;
	logic [2:0]                  outCtrlB;
	logic [2:0]                  outCtrlC;
	logic [2:0]                  outCtrlD;

	// Write and read decode
	logic                        wrEn;
	logic [15:0]                 wrIdx;
	logic [7:0]                  wrByte;
	logic                        wrMapped;
	logic                        rdTake;
	logic [15:0]                 rdIdx;
	logic [31:0]                 rdValue;
	logic                        rdMapped;
	logic                        clearFlagWrite;
	logic [tcc_pkg::INT_BITS-1:0] intEvents;
	logic [tcc_pkg::INT_BITS-1:0] intClear;

	// Merge enabled byte lanes of a write into a counter-wide register
	function automatic logic [CNT_W-1:0] mergeWord(input logic [CNT_W-1:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [CNT_W-1:0] res;
		res = old;
		for (int i = 0; i < CNT_W / 8; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Field decode
	assign clrSel   = timerControl[tcc_pkg::CLR_HI:tcc_pkg::CLR_LO];
	assign edgeSel  = timerControl[tcc_pkg::EDGE_HI:tcc_pkg::EDGE_LO];
	assign pscSel   = timerControl[tcc_pkg::PSC_HI:tcc_pkg::PSC_LO];
	assign outCtrlB = ioControlAb[tcc_pkg::OUTH_HI:tcc_pkg::OUTH_LO];
	assign outCtrlA = ioControlAb[tcc_pkg::OUTL_HI:tcc_pkg::OUTL_LO];
	assign outCtrlD = ioControlCd[tcc_pkg::OUTH_HI:tcc_pkg::OUTH_LO];
	assign outCtrlC = ioControlCd[tcc_pkg::OUTL_HI:tcc_pkg::OUTL_LO];

	////////////////////////////////////////////////////////////////////////////////
	// Free-running prescaler divider
	always_ff @(posedge clk) begin
		if (rst) begin
			divCnt     <= 3'h0;
			prevDivClk <= 1'b0;
		end else begin
			divCnt     <= divCnt + 3'h1;
			prevDivClk <= divClk;
		end
	end

	// Select the divided clock phase
	always_comb begin
		if (pscSel == tcc_pkg::PSC_DIV2) begin
			divClk = divCnt[0];
		end else if (pscSel == tcc_pkg::PSC_DIV4) begin
			divClk = divCnt[1];
		end else if (pscSel == tcc_pkg::PSC_DIV8) begin
			divClk = divCnt[2];
		end else begin
			divClk = 1'b0;
		end
	end

	// Count enable from the selected edge of the selected clock
	always_comb begin
		if (pscSel == tcc_pkg::PSC_DIV1) begin
			countTick = 1'b1;
		end else if (edgeSel == tcc_pkg::EDGE_RISE) begin
			countTick = divClk & ~prevDivClk;
		end else if (edgeSel == tcc_pkg::EDGE_FALL) begin
			countTick = ~divClk & prevDivClk;
		end else begin
			countTick = divClk ^ prevDivClk;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare matches are taken at the count edge
	assign matchA   = countTick & (channelCounter == generalRegA);
	assign matchB   = countTick & (channelCounter == generalRegB);
	assign matchC   = countTick & (channelCounter == generalRegC);
	assign matchD   = countTick & (channelCounter == generalRegD);
	assign overflow = countTick & (&channelCounter);

	// Clear source selection
	always_comb begin
		if (clrSel == tcc_pkg::CLR_ON_A) begin
			clearHit = matchA;
		end else if (clrSel == tcc_pkg::CLR_ON_B) begin
			clearHit = matchB;
		end else if (clrSel == tcc_pkg::CLR_ON_C) begin
			clearHit = matchC;
		end else if (clrSel == tcc_pkg::CLR_ON_D) begin
			clearHit = matchD;
		end else begin
			clearHit = 1'b0;
		end
	end

	// Channel counter; a software write wins over counting
	always_ff @(posedge clk) begin
		if (rst) begin
			channelCounter <= '0;
		end else if (wrEn && wrIdx == tcc_pkg::IDX_CHANNEL_CNT) begin
			channelCounter <= mergeWord(channelCounter, wDataReg, wStrbReg);
		end else if (clearHit) begin
			channelCounter <= '0;
		end else if (countTick) begin
			channelCounter <= channelCounter + CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin outputs from compare matches
	always_ff @(posedge clk) begin
		if (rst) begin
			compareOutA <= 1'b0;
			pwmOutB     <= 1'b0;
			pwmOutC     <= 1'b0;
			pwmOutD     <= 1'b0;
		end else if (pwmModeEn) begin
			// Period match resets, duty matches set
			if (matchA) begin
				pwmOutB <= 1'b0;
				pwmOutC <= 1'b0;
				pwmOutD <= 1'b0;
			end else begin
				if (matchB) pwmOutB <= 1'b1;
				if (matchC) pwmOutC <= 1'b1;
				if (matchD) pwmOutD <= 1'b1;
			end
		end else begin
			// Field 000 leaves each pin untouched
			if (matchA && outCtrlA != tcc_pkg::OUT_OFF) begin
				compareOutA <= outCtrlA == tcc_pkg::OUT_TOGGLE ? ~compareOutA
					: outCtrlA == tcc_pkg::OUT_HIGH;
			end
			if (matchB && outCtrlB != tcc_pkg::OUT_OFF) begin
				pwmOutB <= outCtrlB == tcc_pkg::OUT_TOGGLE ? ~pwmOutB
					: outCtrlB == tcc_pkg::OUT_HIGH;
			end
			if (matchC && outCtrlC != tcc_pkg::OUT_OFF) begin
				pwmOutC <= outCtrlC == tcc_pkg::OUT_TOGGLE ? ~pwmOutC
					: outCtrlC == tcc_pkg::OUT_HIGH;
			end
			if (matchD && outCtrlD != tcc_pkg::OUT_OFF) begin
				pwmOutD <= outCtrlD == tcc_pkg::OUT_TOGGLE ? ~pwmOutD
					: outCtrlD == tcc_pkg::OUT_HIGH;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus write channels: address and data held until both arrive
	assign wrEn   = awHeld & wHeld & ~bvalidReg;
	assign wrIdx  = awAddrReg[tcc_pkg::ADDR_W-1:2];
	assign wrByte = wStrbReg[0] ? wDataReg[7:0] : tcc_pkg::RST_BYTE;

	always_ff @(posedge clk) begin
		if (rst) begin
			awHeld    <= 1'b0;
			wHeld     <= 1'b0;
			awAddrReg <= '0;
			wDataReg  <= 32'h0;
			wStrbReg  <= 4'h0;
		end else begin
			if (axiReq.awvalid && axiRsp.awready) begin
				awHeld    <= 1'b1;
				awAddrReg <= axiReq.awaddr;
			end else if (wrEn) begin
				awHeld <= 1'b0;
			end
			if (axiReq.wvalid && axiRsp.wready) begin
				wHeld    <= 1'b1;
				wDataReg <= axiReq.wdata;
				wStrbReg <= axiReq.wstrb;
			end else if (wrEn) begin
				wHeld <= 1'b0;
			end
		end
	end

	// Write decode
	always_comb begin
		if (wrIdx == tcc_pkg::IDX_TIMER_CONTROL || wrIdx == tcc_pkg::IDX_IO_CONTROL_AB
				|| wrIdx == tcc_pkg::IDX_IO_CONTROL_CD || wrIdx == tcc_pkg::IDX_TIMER_STATUS
				|| wrIdx == tcc_pkg::IDX_CHANNEL_CNT || wrIdx == tcc_pkg::IDX_PWM_MODE
				|| wrIdx == tcc_pkg::IDX_GENERAL_A || wrIdx == tcc_pkg::IDX_GENERAL_B
				|| wrIdx == tcc_pkg::IDX_GENERAL_C || wrIdx == tcc_pkg::IDX_GENERAL_D
				|| wrIdx == tcc_pkg::IDX_INT_STATUS || wrIdx == tcc_pkg::IDX_INT_MASK) begin
			wrMapped = 1'b1;
		end else begin
			wrMapped = 1'b0;
		end
	end

	// Write response
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalidReg <= 1'b0;
			brespReg  <= tcc_pkg::RESP_OKAY;
		end else if (wrEn) begin
			bvalidReg <= 1'b1;
			brespReg  <= wrMapped ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
		end else if (axiReq.bready) begin
			bvalidReg <= 1'b0;
		end
	end

	// Control and compare registers
	always_ff @(posedge clk) begin
		if (rst) begin
			timerControl <= tcc_pkg::RST_BYTE;
			ioControlAb  <= tcc_pkg::RST_BYTE;
			ioControlCd  <= tcc_pkg::RST_BYTE;
			pwmModeEn    <= 1'b0;
			generalRegA  <= '1;
			generalRegB  <= '1;
			generalRegC  <= '1;
			generalRegD  <= '1;
			intMask      <= '0;
		end else if (wrEn) begin
			if (wrIdx == tcc_pkg::IDX_TIMER_CONTROL && wStrbReg[0]) begin
				timerControl <= wrByte;
			end else if (wrIdx == tcc_pkg::IDX_IO_CONTROL_AB && wStrbReg[0]) begin
				ioControlAb <= wrByte;
			end else if (wrIdx == tcc_pkg::IDX_IO_CONTROL_CD && wStrbReg[0]) begin
				ioControlCd <= wrByte;
			end else if (wrIdx == tcc_pkg::IDX_PWM_MODE && wStrbReg[0]) begin
				pwmModeEn <= wrByte[0];
			end else if (wrIdx == tcc_pkg::IDX_GENERAL_A) begin
				generalRegA <= mergeWord(generalRegA, wDataReg, wStrbReg);
			end else if (wrIdx == tcc_pkg::IDX_GENERAL_B) begin
				generalRegB <= mergeWord(generalRegB, wDataReg, wStrbReg);
			end else if (wrIdx == tcc_pkg::IDX_GENERAL_C) begin
				generalRegC <= mergeWord(generalRegC, wDataReg, wStrbReg);
			end else if (wrIdx == tcc_pkg::IDX_GENERAL_D) begin
				generalRegD <= mergeWord(generalRegD, wDataReg, wStrbReg);
			end else if (wrIdx == tcc_pkg::IDX_INT_MASK && wStrbReg[0]) begin
				intMask <= wrByte[tcc_pkg::INT_BITS-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Match A flag: cleared by a zero write only after it was read as one
	assign clearFlagWrite = wrEn && wrIdx == tcc_pkg::IDX_TIMER_STATUS && wStrbReg[0]
		&& !wDataReg[tcc_pkg::FLAG_A] && flagReadSeen;

	always_ff @(posedge clk) begin
		if (rst) begin
			matchAFlag   <= 1'b0;
			flagReadSeen <= 1'b0;
		end else begin
			if (matchA) begin
				matchAFlag <= 1'b1; // set wins over clear
			end else if (clearFlagWrite) begin
				matchAFlag <= 1'b0;
			end
			if (clearFlagWrite || matchA) begin
				flagReadSeen <= 1'b0;
			end else if (rdTake && rdIdx == tcc_pkg::IDX_TIMER_STATUS && matchAFlag) begin
				flagReadSeen <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sticky interrupt status, write one to clear, set wins
	assign intEvents = {overflow, matchD, matchC, matchB, matchA};
	assign intClear  = (wrEn && wrIdx == tcc_pkg::IDX_INT_STATUS && wStrbReg[0])
		? wDataReg[tcc_pkg::INT_BITS-1:0] : '0;

	always_ff @(posedge clk) begin
		if (rst) begin
			intStatus <= '0;
			irq       <= 1'b0;
		end else begin
			intStatus <= (intStatus & ~intClear) | intEvents;
			irq       <= |(intStatus & intMask);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus read channel
	assign rdTake = axiReq.arvalid & axiRsp.arready;
	assign rdIdx  = axiReq.araddr[tcc_pkg::ADDR_W-1:2];

	// Read decode
	always_comb begin
		rdValue  = 32'h0;
		rdMapped = 1'b1;
		if (rdIdx == tcc_pkg::IDX_TIMER_CONTROL) begin
			rdValue[7:0] = timerControl;
		end else if (rdIdx == tcc_pkg::IDX_IO_CONTROL_AB) begin
			rdValue[7:0] = ioControlAb;
		end else if (rdIdx == tcc_pkg::IDX_IO_CONTROL_CD) begin
			rdValue[7:0] = ioControlCd;
		end else if (rdIdx == tcc_pkg::IDX_TIMER_STATUS) begin
			rdValue[tcc_pkg::FLAG_A] = matchAFlag;
		end else if (rdIdx == tcc_pkg::IDX_CHANNEL_CNT) begin
			rdValue[CNT_W-1:0] = channelCounter;
		end else if (rdIdx == tcc_pkg::IDX_PWM_MODE) begin
			rdValue[0] = pwmModeEn;
		end else if (rdIdx == tcc_pkg::IDX_GENERAL_A) begin
			rdValue[CNT_W-1:0] = generalRegA;
		end else if (rdIdx == tcc_pkg::IDX_GENERAL_B) begin
			rdValue[CNT_W-1:0] = generalRegB;
		end else if (rdIdx == tcc_pkg::IDX_GENERAL_C) begin
			rdValue[CNT_W-1:0] = generalRegC;
		end else if (rdIdx == tcc_pkg::IDX_GENERAL_D) begin
			rdValue[CNT_W-1:0] = generalRegD;
		end else if (rdIdx == tcc_pkg::IDX_INT_STATUS) begin
			rdValue[tcc_pkg::INT_BITS-1:0] = intStatus;
		end else if (rdIdx == tcc_pkg::IDX_INT_MASK) begin
			rdValue[tcc_pkg::INT_BITS-1:0] = intMask;
		end else begin
			rdMapped = 1'b0;
		end
	end

	// Read data registered one cycle after the address is taken
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalidReg <= 1'b0;
			rdataReg  <= 32'h0;
			rrespReg  <= tcc_pkg::RESP_OKAY;
		end else if (rdTake) begin
			rvalidReg <= 1'b1;
			rdataReg  <= rdValue;
			rrespReg  <= rdMapped ? tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
		end else if (axiReq.rready) begin
			rvalidReg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Slave outputs
	assign axiRsp.awready = ~awHeld & ~bvalidReg;
	assign axiRsp.wready  = ~wHeld & ~bvalidReg;
	assign axiRsp.bvalid  = bvalidReg;
	assign axiRsp.bresp   = brespReg;
	assign axiRsp.arready = ~rvalidReg;
	assign axiRsp.rvalid  = rvalidReg;
	assign axiRsp.rdata   = rdataReg;
	assign axiRsp.rresp   = rrespReg;

endmodule

// >>> dv/tcc_timer_channel_checker.sv
module tcc_timer_channel_checker #(
	parameter int CNT_W = 16 // Counter width, as in the design
) (
	input wire logic                  clk,         // Clock
	input wire logic                  rst,         // Synchronous reset
	input wire tcc_pkg::tcc_axi_req_s axiReq,      // Bus requests
	input wire tcc_pkg::tcc_axi_rsp_s axiRsp,      // Bus answers
	input wire logic                  compareOutA, // Compare pin A
	input wire logic                  pwmOutB,     // Chopping pin B
	input wire logic                  pwmOutC,     // Chopping pin C
	input wire logic                  pwmOutD,     // Chopping pin D
	input wire logic                  irq          // Interrupt
);
	logic [15:0] awIdx;
	logic [7:0]  wByte;
	logic        bPrev;
	logic [7:0]  ab;
	logic [7:0]  cd;
	logic [7:0]  msk;
	logic        pwm;
	logic        quiet;

	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the written control bytes, applied when the write answer shows
	always_ff @(posedge clk) begin
		if (rst) begin
			bPrev <= 1'b0;
			ab <= 8'h00;
			cd <= 8'h00;
			msk <= 8'h00;
			pwm <= 1'b0;
		end else begin
			bPrev <= axiRsp.bvalid;
			if (axiReq.awvalid && axiRsp.awready) awIdx <= axiReq.awaddr[17:2];
			if (axiReq.wvalid && axiRsp.wready) wByte <= axiReq.wdata[7:0];
			if (axiRsp.bvalid && !bPrev && axiRsp.bresp == tcc_pkg::RESP_OKAY) begin
				case (awIdx)
					tcc_pkg::IDX_IO_CONTROL_AB: ab <= wByte;
					tcc_pkg::IDX_IO_CONTROL_CD: cd <= wByte;
					tcc_pkg::IDX_INT_MASK: msk <= wByte;
					tcc_pkg::IDX_PWM_MODE: pwm <= wByte[0];
					default: ;
				endcase
			end
		end
	end

	// Settled, outside chopping mode, no write landing
	assign quiet = !pwm && !axiRsp.bvalid;

	////////////////////////////////////////////////////////////////////////////////
	// Pins with output disabled hold while quiet; masked irq stays low
	a_pin_a_off: assert property (@(posedge clk) disable iff (rst)
		quiet && ab[2:0] == 3'h0 |-> $stable(compareOutA)) else $error("pin A moved while off");
	a_pin_b_off: assert property (@(posedge clk) disable iff (rst)
		quiet && ab[6:4] == 3'h0 |-> $stable(pwmOutB)) else $error("pin B moved while off");
	a_pin_c_off: assert property (@(posedge clk) disable iff (rst)
		quiet && cd[2:0] == 3'h0 |-> $stable(pwmOutC)) else $error("pin C moved while off");
	a_pin_d_off: assert property (@(posedge clk) disable iff (rst)
		quiet && cd[6:4] == 3'h0 |-> $stable(pwmOutD)) else $error("pin D moved while off");
	a_irq_masked: assert property (@(posedge clk) disable iff (rst)
		!axiRsp.bvalid && msk[4:0] == 5'h00 |-> !irq) else $error("irq high while masked");

	// Bus answers
	a_read_answer: assert property (@(posedge clk) disable iff (rst)
		axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready)
		else $error("read answer not one cycle after address");
	a_read_busy: assert property (@(posedge clk) disable iff (rst)
		axiRsp.rvalid |-> !axiRsp.arready) else $error("read address taken while busy");
	a_read_done: assert property (@(posedge clk) disable iff (rst)
		axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid) else $error("read answer stuck");
	a_write_done: assert property (@(posedge clk) disable iff (rst)
		axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid) else $error("write answer stuck");
endmodule

bind tcc_timer_channel tcc_timer_channel_checker #(.CNT_W(CNT_W)) chk_u (.clk(clk), .rst(rst),
	.axiReq(axiReq), .axiRsp(axiRsp), .compareOutA(compareOutA), .pwmOutB(pwmOutB),
	.pwmOutC(pwmOutC), .pwmOutD(pwmOutD), .irq(irq));

// >>> dv/tcc_timer_channel_bench.sv
module tcc_timer_channel_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [1:0] OK = tcc_pkg::RESP_OKAY;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	tcc_pkg::tcc_axi_req_s axiReq = '0;
	tcc_pkg::tcc_axi_rsp_s axiRsp;
	logic                  compareOutA;
	logic                  pwmOutB;
	logic                  pwmOutC;
	logic                  pwmOutD;
	logic                  irq;
	logic [2:0]            pins;
	int                    badCount = 0;
	int                    nCompared = 0;

	assign pins = {pwmOutD, pwmOutC, pwmOutB};

	always #5 clk = ~clk;

	tcc_timer_channel #(.CNT_W(16)) dut_u (.clk(clk), .rst(rst), .axiReq(axiReq),
		.axiRsp(axiRsp), .compareOutA(compareOutA), .pwmOutB(pwmOutB), .pwmOutC(pwmOutC),
		.pwmOutD(pwmOutD), .irq(irq));

	////////////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and bus tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			badCount++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("compared=%0d mismatches=%0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Handshakes are sampled at the falling edge, where the answer has settled
	task automatic axw(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
		int n;
		logic awGo;
		logic wGo;
		logic bGo;
		logic [1:0] resp;
		@(posedge clk);
		axiReq.awaddr <= {idx, 2'b00};
		axiReq.wdata <= d;
		axiReq.wstrb <= 4'hF;
		axiReq.awvalid <= 1'b1;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			awGo = axiRsp.awready;
			wGo = axiRsp.wready;
			bGo = axiRsp.bvalid;
			resp = axiRsp.bresp;
			@(posedge clk);
			n++;
			if (awGo) axiReq.awvalid <= 1'b0;
			if (wGo) axiReq.wvalid <= 1'b0;
		end while (bGo !== 1'b1 && n < 50);
		axiReq.bready <= 1'b0;
		check({31'h0, bGo}, 32'h1);
		check({30'h0, resp}, {30'h0, er});
	endtask

	task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp, input logic [1:0] er);
		int n;
		logic arGo;
		logic rGo;
		logic [31:0] data;
		logic [1:0] resp;
		@(posedge clk);
		axiReq.araddr <= {idx, 2'b00};
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		n = 0;
		do begin
			@(negedge clk);
			arGo = axiRsp.arready;
			rGo = axiRsp.rvalid;
			data = axiRsp.rdata;
			resp = axiRsp.rresp;
			@(posedge clk);
			n++;
			if (arGo) axiReq.arvalid <= 1'b0;
		end while (rGo !== 1'b1 && n < 50);
		axiReq.rready <= 1'b0;
		check(data, exp);
		check({30'h0, resp}, {30'h0, er});
	endtask

	// Edges until one chopping pin shows the wanted level
	task automatic waitLevel(input int sel, input logic lvl, output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pins[sel] !== lvl && n < 200);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_flag;
		rdchk(tcc_pkg::IDX_TIMER_STATUS, 32'h0, OK);
		axw(tcc_pkg::IDX_GENERAL_A, 32'h20, OK);
		axw(tcc_pkg::IDX_TIMER_CONTROL, 32'h20, OK);
		repeat (40) @(posedge clk);
		axw(tcc_pkg::IDX_GENERAL_A, 32'hFFFF, OK);
		axw(tcc_pkg::IDX_TIMER_STATUS, 32'h0, OK);
		rdchk(tcc_pkg::IDX_TIMER_STATUS, 32'h1, OK);
		axw(tcc_pkg::IDX_TIMER_STATUS, 32'h0, OK);
		rdchk(tcc_pkg::IDX_TIMER_STATUS, 32'h0, OK);
		check({31'h0, irq}, 32'h0);
		for (int i = 0; i < 3; i++) begin
			axw(tcc_pkg::IDX_INT_MASK, 32'(i % 2 == 0), OK);
			repeat (3) @(posedge clk);
			check({31'h0, irq}, 32'(i % 2 == 0));
		end
		rdchk(tcc_pkg::IDX_INT_STATUS, 32'h1, OK);
		axw(tcc_pkg::IDX_INT_STATUS, 32'h1F, OK);
		repeat (3) @(posedge clk);
		check({31'h0, irq}, 32'h0);
	endtask

	task automatic t_off;
		axw(tcc_pkg::IDX_GENERAL_A, 32'h9, OK);
		axw(tcc_pkg::IDX_GENERAL_B, 32'h2, OK);
		axw(tcc_pkg::IDX_GENERAL_C, 32'h5, OK);
		axw(tcc_pkg::IDX_GENERAL_D, 32'h7, OK);
		// Restart the count below the period so matches come at once
		axw(tcc_pkg::IDX_CHANNEL_CNT, 32'h0, OK);
		for (int i = 0; i < 4; i++) begin
			axw(tcc_pkg::IDX_IO_CONTROL_AB, (i == 1) ? 32'h22 : (i == 3) ? 32'h11 : 32'h0, OK);
			axw(tcc_pkg::IDX_IO_CONTROL_CD, (i == 1) ? 32'h22 : (i == 3) ? 32'h11 : 32'h0, OK);
			repeat (30) @(posedge clk);
			check({28'h0, pins, compareOutA}, (i == 1 || i == 2) ? 32'hF : 32'h0);
		end
	endtask

	task automatic t_pwm;
		int lowW;
		int hiW;
		int g[3] = '{2, 5, 7};
		axw(tcc_pkg::IDX_PWM_MODE, 32'h1, OK);
		for (int p = 0; p < 4; p++) begin
			axw(tcc_pkg::IDX_TIMER_CONTROL, {24'h0, 3'h1, 2'(p % 2), 3'(p)}, OK);
			for (int s = 0; s < 3; s++) begin
				waitLevel(s, 1'b1, lowW);
				waitLevel(s, 1'b0, lowW);
				waitLevel(s, 1'b1, lowW);
				waitLevel(s, 1'b0, hiW);
				check(lowW, (g[s] + 1) * (1 << p));
				check(lowW + hiW, 10 * (1 << p));
			end
		end
	endtask

	task automatic t_regs;
		logic [15:0] idx[5] = '{tcc_pkg::IDX_TIMER_CONTROL, tcc_pkg::IDX_IO_CONTROL_AB,
			tcc_pkg::IDX_IO_CONTROL_CD, tcc_pkg::IDX_TIMER_STATUS, tcc_pkg::IDX_GENERAL_A};
		@(posedge clk);
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) rdchk(idx[i], (i == 4) ? 32'hFFFF : 32'h0, OK);
		for (int i = 0; i < 3; i++) begin
			axw(idx[i], 32'hA5, OK);
			rdchk(idx[i], 32'hA5, OK);
		end
		rdchk(16'hF704, 32'h0, tcc_pkg::RESP_SLVERR);
		axw(16'hF704, 32'h1, tcc_pkg::RESP_SLVERR);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and watchdog
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_flag;
		t_off;
		t_pwm;
		t_regs;
		close_out;
	end

	initial begin
		#100000;
		badCount++;
		close_out;
	end
endmodule
